//--- inc/ubd_pkg.sv
// Purpose: constants for the baud divisor and clock edge block
// Assumes: 8-bit register port, 2-bit address
// Notes:   shared location steered by map_select on writes
package ubd_pkg;
  localparam int          ADDR_W          = 2;
  localparam int          DATA_W          = 8;
  localparam int          DIV_W           = 12;
  localparam int          DIV_HI_W        = 4;
  localparam int          BASE_W          = 4;
  localparam logic [1:0]  OFS_DIV_LOW     = 2'h0;
  localparam logic [1:0]  OFS_SHARED      = 2'h1;
  localparam logic [1:0]  OFS_CONTROL     = 2'h2;
  localparam logic [1:0]  OFS_STATUS      = 2'h3;
  localparam int          BIT_MAP_SEL     = 7;
  localparam int          BIT_SYNC_MODE   = 6;
  localparam int          BIT_EDGE_SEL    = 0;
  localparam int          BIT_RD_HI_SEL   = 0;
  localparam int          BIT_DBL_SPEED   = 1;
  localparam logic [6:0]  FRAME_RESET     = 7'h06;
  localparam logic [3:0]  DIV_HI_RESET    = 4'h0;
  localparam logic [7:0]  DIV_LO_RESET    = 8'h00;
  localparam logic [3:0]  BASE_LAST_NORM  = 4'hF;
  localparam logic [3:0]  BASE_LAST_DBL   = 4'h7;
endpackage

//--- logic/ubd_prescaler.sv
// Purpose: down-counting baud prescaler with immediate reload
// Assumes: reload value is the full divisor
// Notes:   tick period is divisor plus one cycles
`timescale 1ns/1ps
module ubd_prescaler #(
  parameter int WIDTH = 12
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_reload,
  input  wire logic [WIDTH-1:0] i_reload_value,
  input  wire logic [WIDTH-1:0] i_divisor,
  output logic      [WIDTH-1:0] o_count,
  output logic                  o_tick
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire              at_zero = (count_reg == '0);

  // reload beats the running count
  assign count_next = i_reload ? i_reload_value :
                      at_zero  ? i_divisor :
                      count_reg - WIDTH'(1);

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;
  assign o_tick  = at_zero & ~i_reload;
endmodule

//--- logic/ubd_top.sv
// Purpose: baud divisor registers, prescaler and clock edge selection
// Assumes: sync clock pin is an external input in sync mode
// Notes:   launch and sample pulses are one cycle long, except async sample stays high while the divisor is zero
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ubd_top (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_sync_clock_pin,
  output logic      [7:0] o_rdata,
  output logic            o_tx_launch,
  output logic            o_rx_sample,
  output logic            o_sync_mode
);
  logic [3:0] div_hi_reg;
  logic [7:0] div_lo_reg;
  logic [6:0] frame_reg;
  logic [1:0] ctrl_reg;
  logic [7:0] rdata_reg;
  logic [3:0] base_reg;
  logic [3:0] base_next;
  logic       sync_s1_reg;
  logic       sync_s2_reg;
  logic       sync_s3_reg;
  logic       sync_lvl_reg;
  logic       tx_launch_reg;
  logic       rx_sample_reg;
  logic       sync_mode_reg;
  logic [11:0] pre_count;
  logic        pre_tick;

  // offset match, shared by write decode and read mux
  function automatic logic ofs_hit(input logic [1:0] addr,
                                   input logic [1:0] ofs);
    return addr == ofs;
  endfunction

  // register decode
  wire wr_low    = i_wr & ofs_hit(i_addr, ubd_pkg::OFS_DIV_LOW);
  wire wr_shared = i_wr & ofs_hit(i_addr, ubd_pkg::OFS_SHARED);
  wire wr_ctrl   = i_wr & ofs_hit(i_addr, ubd_pkg::OFS_CONTROL);
  wire to_frame  = wr_shared & i_wdata[ubd_pkg::BIT_MAP_SEL];
  wire to_div_hi = wr_shared & ~i_wdata[ubd_pkg::BIT_MAP_SEL];
  wire sync_mode = frame_reg[ubd_pkg::BIT_SYNC_MODE];
  wire edge_sel  = frame_reg[ubd_pkg::BIT_EDGE_SEL];
  wire dbl_speed = ctrl_reg[ubd_pkg::BIT_DBL_SPEED];
  wire rd_hi_sel = ctrl_reg[ubd_pkg::BIT_RD_HI_SEL];
  wire [11:0] divisor = {div_hi_reg, div_lo_reg};
  wire [11:0] reload_value = {div_hi_reg, i_wdata};

  // read mux
  wire [7:0] shared_rd = rd_hi_sel ? {4'h0, div_hi_reg}
                                   : {1'b1, frame_reg};
  wire [7:0] status_rd = {3'h0, base_reg, sync_lvl_reg};
  wire [7:0] rd_mux = ofs_hit(i_addr, ubd_pkg::OFS_DIV_LOW) ? div_lo_reg :
                      ofs_hit(i_addr, ubd_pkg::OFS_SHARED)  ? shared_rd :
                      ofs_hit(i_addr, ubd_pkg::OFS_CONTROL) ? {6'h00, ctrl_reg} :
                      status_rd;
  wire [7:0] rdata_next = i_rd ? rd_mux : 8'h00;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_hi_reg <= ubd_pkg::DIV_HI_RESET;
      div_lo_reg <= ubd_pkg::DIV_LO_RESET;
      frame_reg  <= ubd_pkg::FRAME_RESET;
      ctrl_reg   <= 2'h0;
      rdata_reg  <= 8'h00;
    end else begin
      if (to_div_hi) begin
        div_hi_reg <= i_wdata[3:0];
      end
      if (wr_low) begin
        div_lo_reg <= i_wdata;
      end
      if (to_frame) begin
        frame_reg <= i_wdata[6:0];
      end
      if (wr_ctrl) begin
        ctrl_reg <= i_wdata[1:0];
      end
      rdata_reg <= rdata_next;
    end
  end

  ubd_prescaler #(
    .WIDTH (ubd_pkg::DIV_W)
  ) u_prescaler (
    .i_sys_clk      (i_sys_clk),
    .i_sys_rst      (i_sys_rst),
    .i_reload       (wr_low),
    .i_reload_value (reload_value),
    .i_divisor      (divisor),
    .o_count        (pre_count),
    .o_tick         (pre_tick)
  );

  // base divider: 16 or 8 prescaler ticks per bit
  wire [3:0] base_last = dbl_speed ? ubd_pkg::BASE_LAST_DBL
                                   : ubd_pkg::BASE_LAST_NORM;
  wire       base_wrap = pre_tick & (base_reg >= base_last);
  assign base_next = wr_low    ? 4'h0 :
                     base_wrap ? 4'h0 :
                     pre_tick  ? base_reg + 4'h1 :
                     base_reg;

  // sync clock pin: three flops, change taken when second and third agree
  wire sync_rise = sync_s2_reg & sync_s3_reg & ~sync_lvl_reg;
  wire sync_fall = ~sync_s2_reg & ~sync_s3_reg & sync_lvl_reg;
  wire launch_edge = edge_sel ? sync_fall : sync_rise;
  wire sample_edge = edge_sel ? sync_rise : sync_fall;
  wire tx_launch_next = sync_mode ? launch_edge : base_wrap;
  wire rx_sample_next = sync_mode ? sample_edge : pre_tick;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_reg      <= 4'h0;
      sync_s1_reg   <= 1'b0;
      sync_s2_reg   <= 1'b0;
      sync_s3_reg   <= 1'b0;
      sync_lvl_reg  <= 1'b0;
      tx_launch_reg <= 1'b0;
      rx_sample_reg <= 1'b0;
      sync_mode_reg <= 1'b0;
    end else begin
      base_reg      <= base_next;
      sync_s1_reg   <= i_sync_clock_pin;
      sync_s2_reg   <= sync_s1_reg;
      sync_s3_reg   <= sync_s2_reg;
      if (sync_s2_reg == sync_s3_reg) begin
        sync_lvl_reg <= sync_s3_reg;
      end
      tx_launch_reg <= tx_launch_next;
      rx_sample_reg <= rx_sample_next;
      sync_mode_reg <= sync_mode;
    end
  end

  assign o_rdata     = rdata_reg;
  assign o_tx_launch = tx_launch_reg;
  assign o_rx_sample = rx_sample_reg;
  assign o_sync_mode = sync_mode_reg;

  // checks
  launch_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    sync_mode && !edge_sel && sync_rise |=> o_tx_launch && !o_rx_sample)
    else $error("launch not on rising edge with edge select zero");

  sample_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    sync_mode && edge_sel && sync_rise |=> o_rx_sample && !o_tx_launch)
    else $error("sample not on rising edge with edge select one");

  high_read_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_rd && i_addr == ubd_pkg::OFS_SHARED && rd_hi_sel
    |=> o_rdata == {4'h0, $past(div_hi_reg)})
    else $error("divisor high read wrong");

  frame_read_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_rd && i_addr == ubd_pkg::OFS_SHARED && !rd_hi_sel
    |=> o_rdata[7] && o_rdata[6:0] == $past(frame_reg))
    else $error("frame config read wrong");

  div_high_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    to_div_hi |=> div_hi_reg == $past(i_wdata[3:0]) && $stable(frame_reg))
    else $error("divisor high write misrouted");

  reload_now_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_low |=> pre_count == {div_hi_reg, $past(i_wdata)})
    else $error("prescaler not reloaded on low write");

  base_div_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !sync_mode && pre_tick && !wr_low && base_reg == (dbl_speed ? 4'h7 : 4'hF)
    |=> o_tx_launch && base_reg == 4'h0)
    else $error("base divisor wrong");

  async_mode_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !sync_mode && !pre_tick |=> !o_tx_launch && !o_rx_sample)
    else $error("async pulses not from prescaler");

  rate_count_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    pre_tick && !wr_low |=> pre_count == $past(divisor))
    else $error("prescaler period wrong");

  fall_launch_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    sync_mode && edge_sel && sync_fall
    |=> o_tx_launch && !o_rx_sample)
    else $error("launch not on falling edge with edge select one");

  fall_sample_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    sync_mode && !edge_sel && sync_fall
    |=> o_rx_sample && !o_tx_launch)
    else $error("sample not on falling edge with edge select zero");

  sync_level_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    sync_s2_reg == sync_s3_reg
    |=> sync_lvl_reg == $past(sync_s3_reg))
    else $error("sync clock level not taken when flops agree");

  sync_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    sync_mode && !sync_rise && !sync_fall
    |=> !o_tx_launch && !o_rx_sample)
    else $error("sync pulse without clock edge");

  mode_copy_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    1'b1
    |=> o_sync_mode == $past(sync_mode))
    else $error("sync mode output wrong");

  frame_write_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    to_frame
    |=> frame_reg == $past(i_wdata[6:0]) && $stable(div_hi_reg))
    else $error("frame config write misrouted");

  low_write_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_low
    |=> div_lo_reg == $past(i_wdata) && $stable(div_hi_reg))
    else $error("divisor low write wrong");

  ctrl_write_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_ctrl
    |=> ctrl_reg == $past(i_wdata[1:0]))
    else $error("control write wrong");

  base_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !pre_tick && !wr_low
    |=> $stable(base_reg))
    else $error("base counter moved without tick");

  reload_base_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_low && !sync_mode
    |=> base_reg == 4'h0 && !o_tx_launch && !o_rx_sample)
    else $error("low write did not restart base counter");
endmodule

//--- tb/ubd_remote_clock.sv
// Purpose: far-side sync clock source for the bench
// Assumes: clock stands low outside frames
// Notes:   half period counted in system cycles
`timescale 1ns/1ps
module ubd_remote_clock #(
  parameter int HALF = 8
) (
  input  wire logic i_sys_clk,
  input  wire logic i_run,
  output logic      o_sync_clock_pin
);
  int cnt = 0;
  always @(posedge i_sys_clk) begin
    if (!i_run) begin
      cnt <= 0;
      o_sync_clock_pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      o_sync_clock_pin <= ~o_sync_clock_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

//--- tb/tb_ubd_top.sv
// Purpose: self-checking bench for the baud divisor block
// Assumes: registered read data one cycle after the strobe
// Notes:   small divisors keep periods short
`timescale 1ns/1ps
module tb_ubd_top;
  logic       i_sys_clk;
  logic       i_sys_rst = 1'b1;
  logic [1:0] i_addr    = 2'h0;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic       run       = 1'b0;
  logic       pin;
  logic [7:0] o_rdata;
  logic       o_tx_launch;
  logic       o_rx_sample;
  logic       o_sync_mode;
  logic [7:0] d;
  logic [7:0] lo;
  logic [7:0] hi;
  int         miscompares = 0;
  int         tests_run = 0;
  int         seed = 29318;
  int         n;
  int         it;
  ubd_top dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_sync_clock_pin(pin),
    .o_rdata(o_rdata), .o_tx_launch(o_tx_launch), .o_rx_sample(o_rx_sample),
    .o_sync_mode(o_sync_mode));
  ubd_remote_clock #(.HALF(8)) remote (.i_sys_clk(i_sys_clk), .i_run(run),
    .o_sync_clock_pin(pin));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  function int exp_tx(int dv, bit dbl);
    return (dbl ? 8 : 16) * (dv + 1);
  endfunction
  task end_of_test;
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // cycles between two pulses of launch or sample, bounded
  task meas(input bit tx, input int lim, output int c);
    int i;
    int k;
    c = 0;
    k = 0;
    for (i = 0; i < lim && k < 2; i++) begin
      @(posedge i_sys_clk);
      if (k == 1) c++;
      if ((tx ? o_tx_launch : o_rx_sample) === 1'b1) k++;
    end
    if (k < 2) begin
      miscompares++;
      end_of_test;
    end
  endtask
  task sync_run(input bit edge_sel);
    int i;
    int nt;
    int nr;
    nt = 0;
    nr = 0;
    wr(2'h1, {7'h60, edge_sel});
    repeat (2) @(posedge i_sys_clk);
    chk("sync_mode", 16'h1, {15'h0, o_sync_mode});
    run <= 1'b1;
    for (i = 0; i < 80; i++) begin
      @(posedge i_sys_clk);
      if (i == 64) run <= 1'b0;
      if (o_tx_launch === 1'b1) begin
        nt++;
        chk("pin_at_launch", {15'h0, ~edge_sel}, {15'h0, pin});
      end
      if (o_rx_sample === 1'b1) begin
        nr++;
        chk("pin_at_sample", {15'h0, edge_sel}, {15'h0, pin});
      end
    end
    chk("launch_count", 16'h4, 16'(nt));
    chk("sample_count", 16'h4, 16'(nr));
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(2'h1, d);
    chk("frame_reset", 16'h86, {8'h0, d});
    wr(2'h2, 8'h01);
    rd(2'h1, d);
    chk("high_reset", 16'h00, {8'h0, d});
    hi = 8'($random(seed)) & 8'h0F;
    wr(2'h1, hi);
    wr(2'h1, 8'h84);
    rd(2'h1, d);
    chk("high_rd", {8'h0, hi}, {8'h0, d});
    wr(2'h2, 8'h00);
    rd(2'h1, d);
    chk("frame_rd", 16'h84, {8'h0, d});
    wr(2'h1, 8'h86);
    chk("sync_mode", 16'h0, {15'h0, o_sync_mode});
    for (it = 0; it < 4; it++) begin
      lo = (it == 0) ? 8'h00 : (8'($random(seed)) & 8'h0F);
      wr(2'h2, {6'h00, it[0], 1'b0});
      wr(2'h1, 8'h0F);
      wr(2'h0, 8'hFF);
      repeat (10) @(posedge i_sys_clk);
      wr(2'h1, 8'h00);
      wr(2'h0, lo);
      meas(1'b0, 2 * int'(lo) + 4, n);
      chk("reload_tick", 16'(int'(lo) + 1), 16'(n));
      rd(2'h0, d);
      chk("low_rd", {8'h0, lo}, {8'h0, d});
      meas(1'b0, 400, n);
      chk("sample_period", 16'(int'(lo) + 1), 16'(n));
      meas(1'b1, 600, n);
      chk("launch_period", 16'(exp_tx(int'(lo), it[0])), 16'(n));
    end
    wr(2'h2, 8'h00);
    sync_run(1'b0);
    sync_run(1'b1);
    end_of_test;
  end
endmodule
